// >>> logic/ptb_pkg.sv
// Shared types and constants of the PCI target back-end port.
// Assumes a single core clock and a 64-bit build.
package ptb_pkg;
  // ===========================================================
  // Widths
  localparam int DATA_W = 64;
  localparam int ADDR_W = 24;
  localparam int LAG_W = 3;
  // ===========================================================
  // APB register offsets and fields
  localparam logic [7:0] OFS_BASE0 = 8'h00;
  localparam logic [7:0] OFS_BASE1 = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [31:0] BASE0_RST = 32'h0000_0000;
  localparam logic [31:0] BASE1_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0008_1003;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_W1_BIT = 1;
  localparam int CTRL_FIRST_LSB = 8;
  localparam int CTRL_NEXT_LSB = 16;
  // ===========================================================
  // PCI commands and window masks
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [31:0] WIN0_MASK = 32'hFF00_0000;
  localparam logic [31:0] WIN1_MASK = 32'hFFFF_FF00;
  // Cycles after a data beat before the next strobe, covering the pin synchronisers.
  localparam logic [2:0] BEAT_GAP = 3'h3;
  // ===========================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_STOP, ST_FINISH} ptb_fsm_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ptb_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ptb_apb_rsp_s;
  typedef struct packed {
    logic [31:0] base0;
    logic [31:0] base1;
    logic [31:0] ctrl;
  } ptb_cfg_s;
  typedef struct packed {
    logic busy;
    logic wide;
    logic [15:0] disc_cnt;
  } ptb_stat_s;
  typedef struct packed {
    logic win0;
    logic win1;
    logic cfg;
    logic rd;
    logic wr;
  } ptb_flags_s;
endpackage

// >>> logic/ptb_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes the inputs are quasi-static across a capture.
`timescale 1ns/1ps
module ptb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ptb_sync_st_s;
  ptb_sync_st_s st;
  ptb_sync_st_s next_st;
  always_comb begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= {RST, RST};
    end else begin
      st <= next_st;
    end
  end
  assign dout = st.s2;
endmodule // ptb_sync

// >>> logic/ptb_apb_regs.sv
// APB slave holding the window bases and control, and reading status.
// Assumes the master keeps the request stable until pready.
`timescale 1ns/1ps
module ptb_apb_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Bus
  input wire ptb_pkg::ptb_apb_req_s req,
  output ptb_pkg::ptb_apb_rsp_s rsp,
  // Block side
  output ptb_pkg::ptb_cfg_s cfg,
  input wire ptb_pkg::ptb_stat_s stat
);
  typedef struct packed {
    ptb_pkg::ptb_cfg_s cfg;
    ptb_pkg::ptb_apb_rsp_s rsp;
  } ptb_regs_st_s;
  ptb_regs_st_s st;
  ptb_regs_st_s next_st;
  logic access;
  logic commit;
  logic hit;
  logic [31:0] rval;
  always_comb begin
    next_st = st;
    access = req.psel && req.penable;
    commit = access && st.rsp.pready;
    hit = 1'b1;
    unique case (req.paddr)
      ptb_pkg::OFS_BASE0: rval = st.cfg.base0;
      ptb_pkg::OFS_BASE1: rval = st.cfg.base1;
      ptb_pkg::OFS_CTRL: rval = st.cfg.ctrl;
      ptb_pkg::OFS_STAT: rval = {14'h0, stat.disc_cnt, stat.wide, stat.busy};
      default: begin
        rval = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    // One wait state: the answer is registered from the first access cycle.
    next_st.rsp.pready = access && !st.rsp.pready;
    next_st.rsp.pslverr = access && !st.rsp.pready && !hit;
    next_st.rsp.prdata = (access && !st.rsp.pready && !req.pwrite) ? rval : 32'h0000_0000;
    if (commit && req.pwrite && hit) begin
      unique case (req.paddr)
        ptb_pkg::OFS_BASE0: next_st.cfg.base0 = req.pwdata;
        ptb_pkg::OFS_BASE1: next_st.cfg.base1 = req.pwdata;
        ptb_pkg::OFS_CTRL: next_st.cfg.ctrl = req.pwdata;
        default: next_st.cfg = st.cfg;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st.cfg <= '{ptb_pkg::BASE0_RST, ptb_pkg::BASE1_RST, ptb_pkg::CTRL_RST};
      st.rsp <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign rsp = st.rsp;
  assign cfg = st.cfg;
endmodule // ptb_apb_regs

// >>> logic/ptb_core.sv
// Back-end port of a PCI target: decodes the address phase, flags the
// window and direction to the back end, and paces data with strobes.
// Assumes PCI pins arrive asynchronously and back-end logic shares core_clk.
`timescale 1ns/1ps
module ptb_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,

  // Register bus
  input wire ptb_pkg::ptb_apb_req_s apb_req,
  output ptb_pkg::ptb_apb_rsp_s apb_rsp,

  // PCI pins from the master
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic req64_n,
  input wire logic idsel,
  input wire logic [7:0] cbe_n,
  input wire logic [ptb_pkg::DATA_W-1:0] ad_in,

  // PCI pins driven by the target
  output logic [ptb_pkg::DATA_W-1:0] ad_out,
  output logic ad_oe,
  output logic trdy_n,
  output logic stop_n,
  output logic devsel_n,
  output logic ack64_n,
  output logic ctl_oe,

  // Back-end indications
  output logic window_zero_hit,
  output logic window_one_hit,
  output logic cfg_space_hit,
  output logic rd_direction_flag,
  output logic wr_direction_flag,
  output logic [ptb_pkg::ADDR_W-1:0] mem_addr,
  output logic xfer_begin_pulse,
  output logic wide_xfer_begin_pulse,
  output logic xfer_end_pulse,

  // Back-end data flow
  output logic rd_lane_lo_strobe,
  output logic rd_lane_hi_strobe,
  output logic [3:0] wr_lane_lo_bytes,
  output logic [3:0] wr_lane_hi_bytes,
  input wire logic backend_src_ready,
  input wire logic backend_sink_ready,
  input wire logic [ptb_pkg::LAG_W-1:0] pipeline_lag_count,

  // Back-end data bus, split into its three signals
  input wire logic [ptb_pkg::DATA_W-1:0] mem_data_in,
  output logic [ptb_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe
);

  // ===========================================================
  // Pin synchronisers
  localparam int PIN_W = 4 + 8 + ptb_pkg::DATA_W;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic frame_s;
  logic irdy_s;
  logic req64_s;
  logic idsel_s;
  logic [7:0] cbe_s;
  logic [ptb_pkg::DATA_W-1:0] ad_s;

  assign pin_raw = {frame_n, irdy_n, req64_n, idsel, cbe_n, ad_in};

  ptb_sync #(
    .W(PIN_W),
    .RST({3'h7, {(PIN_W - 3){1'b0}}})
  ) u_pin_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .din(pin_raw),
    .dout(pin_s)
  );

  assign {frame_s, irdy_s, req64_s, idsel_s, cbe_s, ad_s} = pin_s;

  // ===========================================================
  // Register file
  ptb_pkg::ptb_cfg_s cfg;
  ptb_pkg::ptb_stat_s stat;

  ptb_apb_regs u_regs (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .req(apb_req),
    .rsp(apb_rsp),
    .cfg(cfg),
    .stat(stat)
  );

  // ===========================================================
  // State
  typedef struct packed {
    ptb_pkg::ptb_fsm_e fsm;
    logic frame_d;
    ptb_pkg::ptb_flags_s flags;
    logic wide;
    logic begin_p;
    logic wbegin_p;
    logic end_p;
    logic [ptb_pkg::ADDR_W-1:0] addr;
    logic [ptb_pkg::LAG_W-1:0] lag;
    logic [7:0] wait_cnt;
    logic [2:0] gap;
    logic beat_seen;
    logic real_pend;
    logic last_pend;
    logic rd_lo;
    logic rd_hi;
    logic [3:0] wr_lo;
    logic [3:0] wr_hi;
    logic [ptb_pkg::DATA_W-1:0] md_out;
    logic md_oe;
    logic [ptb_pkg::DATA_W-1:0] ad_out;
    logic ad_oe;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic ack64_n;
    logic ctl_oe;
    logic [15:0] disc_cnt;
  } ptb_core_st_s;

  ptb_core_st_s st;
  ptb_core_st_s next_st;

  // ===========================================================
  // Address phase decode
  logic frame_fall;
  logic [3:0] cmd;
  logic [31:0] adr;
  logic is_mem;
  logic is_io;
  logic is_cfg;
  logic hit0;
  logic hit1;
  logic hitc;
  logic cmd_rd;
  logic any_hit;

  always_comb begin
    frame_fall = st.frame_d && !frame_s;
    cmd = cbe_s[3:0];
    adr = ad_s[31:0];
    is_mem = (cmd == ptb_pkg::CMD_MEM_RD) || (cmd == ptb_pkg::CMD_MEM_WR);
    is_io = (cmd == ptb_pkg::CMD_IO_RD) || (cmd == ptb_pkg::CMD_IO_WR);
    is_cfg = (cmd == ptb_pkg::CMD_CFG_RD) || (cmd == ptb_pkg::CMD_CFG_WR);
    cmd_rd = !cmd[0];
    hit0 = is_mem &&
      ((adr & ptb_pkg::WIN0_MASK) == (cfg.base0 & ptb_pkg::WIN0_MASK));
    hit1 = (is_mem || is_io) && cfg.ctrl[ptb_pkg::CTRL_W1_BIT] &&
      ((adr & ptb_pkg::WIN1_MASK) == (cfg.base1 & ptb_pkg::WIN1_MASK));
    hitc = is_cfg && idsel_s && (adr[1:0] == 2'h0);
    any_hit = cfg.ctrl[ptb_pkg::CTRL_EN_BIT] && (hit0 || hit1 || hitc);
  end

  // ===========================================================
  // Data phase control
  logic go;
  logic lag_now;
  logic [7:0] limit;
  logic [ptb_pkg::ADDR_W-1:0] step;

  always_comb begin
    next_st = st;
    next_st.frame_d = frame_s;
    // Pulses and single-cycle strobes fall back every cycle.
    next_st.begin_p = 1'b0;
    next_st.wbegin_p = 1'b0;
    next_st.end_p = 1'b0;
    next_st.rd_lo = 1'b0;
    next_st.rd_hi = 1'b0;
    next_st.wr_lo = 4'h0;
    next_st.wr_hi = 4'h0;
    next_st.trdy_n = 1'b1;
    next_st.ad_oe = 1'b0;
    next_st.real_pend = 1'b0;
    next_st.last_pend = 1'b0;
    go = 1'b0;
    lag_now = st.lag != '0;
    limit = st.beat_seen ? cfg.ctrl[ptb_pkg::CTRL_NEXT_LSB +: 8] : cfg.ctrl[ptb_pkg::CTRL_FIRST_LSB +: 8];
    step = st.wide ? ptb_pkg::ADDR_W'(8) : ptb_pkg::ADDR_W'(4);

    unique case (st.fsm)
      ptb_pkg::ST_IDLE: begin
        next_st.flags = '0;
        next_st.wide = 1'b0;
        if (frame_fall && any_hit) begin
          next_st.fsm = ptb_pkg::ST_XFER;
          // Flags come up with the begin pulse and hold until completion.
          next_st.flags.win0 = hit0 && !hitc;
          next_st.flags.win1 = hit1 && !hit0 && !hitc;
          next_st.flags.cfg = hitc;
          next_st.flags.rd = cmd_rd;
          next_st.flags.wr = !cmd_rd;
          next_st.wide = !req64_s && is_mem;
          next_st.begin_p = 1'b1;
          next_st.wbegin_p = !req64_s && is_mem;
          next_st.addr = adr[ptb_pkg::ADDR_W-1:0];
          next_st.lag = pipeline_lag_count;
          next_st.wait_cnt = 8'h00;
          next_st.gap = 3'h0;
          next_st.beat_seen = 1'b0;
          next_st.devsel_n = 1'b0;
          next_st.ack64_n = !(!req64_s && is_mem);
          next_st.stop_n = 1'b1;
          next_st.ctl_oe = 1'b1;
        end
      end

      ptb_pkg::ST_XFER: begin
        // A strobe one cycle ago completes its beat on this edge.
        if (st.real_pend) begin
          next_st.trdy_n = 1'b0;
          next_st.beat_seen = 1'b1;
          next_st.gap = ptb_pkg::BEAT_GAP;
          if (st.flags.rd) begin
            next_st.ad_out = mem_data_in;
            next_st.ad_oe = 1'b1;
          end
          if (st.last_pend) begin
            next_st.fsm = ptb_pkg::ST_FINISH;
          end
        end else if (st.gap != 3'h0) begin
          next_st.gap = st.gap - 3'h1;
        end else begin
          if (st.flags.rd) begin
            go = backend_src_ready && !irdy_s;
          end else begin
            go = backend_sink_ready && !irdy_s;
          end
          if (go) begin
            next_st.wait_cnt = 8'h00;
            next_st.addr = st.addr + step;
            if (st.flags.rd) begin
              next_st.rd_lo = 1'b1;
              next_st.rd_hi = st.wide;
            end else begin
              next_st.md_out = ad_s;
              next_st.wr_lo = ~cbe_s[3:0];
              next_st.wr_hi = st.wide ? ~cbe_s[7:4] : 4'h0;
            end
            if (lag_now) begin
              // Address runs ahead; no PCI beat, the back end drops this strobe.
              next_st.lag = st.lag - ptb_pkg::LAG_W'(1);
            end else begin
              next_st.real_pend = 1'b1;
              next_st.last_pend = frame_s;
            end
          end else if (frame_s && irdy_s) begin
            next_st.fsm = ptb_pkg::ST_FINISH;
          end else if (st.wait_cnt >= limit) begin
            // Latency exceeded: stop without data phase completion.
            next_st.stop_n = 1'b0;
            next_st.fsm = ptb_pkg::ST_STOP;
            next_st.disc_cnt = st.disc_cnt + 16'h0001;
          end else begin
            next_st.wait_cnt = st.wait_cnt + 8'h01;
          end
        end
      end

      ptb_pkg::ST_STOP: begin
        // Hold stop until the master lets frame go.
        if (frame_s) begin
          next_st.fsm = ptb_pkg::ST_FINISH;
        end
      end

      ptb_pkg::ST_FINISH: begin
        next_st.end_p = 1'b1;
        next_st.devsel_n = 1'b1;
        next_st.ack64_n = 1'b1;
        next_st.stop_n = 1'b1;
        next_st.ctl_oe = 1'b0;
        next_st.fsm = ptb_pkg::ST_IDLE;
      end
    endcase

    // The back-end bus is driven only during writes; reads leave it to the back end.
    next_st.md_oe = next_st.flags.wr;
  end

  // ===========================================================
  // Registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.fsm <= ptb_pkg::ST_IDLE;
      st.frame_d <= 1'b1;
      st.trdy_n <= 1'b1;
      st.stop_n <= 1'b1;
      st.devsel_n <= 1'b1;
      st.ack64_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ===========================================================
  // Outputs, all straight from the state register
  assign stat = '{st.fsm != ptb_pkg::ST_IDLE, st.wide, st.disc_cnt};

  assign window_zero_hit = st.flags.win0;
  assign window_one_hit = st.flags.win1;
  assign cfg_space_hit = st.flags.cfg;
  assign rd_direction_flag = st.flags.rd;
  assign wr_direction_flag = st.flags.wr;
  assign mem_addr = st.addr;
  assign xfer_begin_pulse = st.begin_p;
  assign wide_xfer_begin_pulse = st.wbegin_p;
  assign xfer_end_pulse = st.end_p;

  assign rd_lane_lo_strobe = st.rd_lo;
  assign rd_lane_hi_strobe = st.rd_hi;
  assign wr_lane_lo_bytes = st.wr_lo;
  assign wr_lane_hi_bytes = st.wr_hi;
  assign mem_data_out = st.md_out;
  assign mem_data_oe = st.md_oe;

  assign ad_out = st.ad_out;
  assign ad_oe = st.ad_oe;
  assign trdy_n = st.trdy_n;
  assign stop_n = st.stop_n;
  assign devsel_n = st.devsel_n;
  assign ack64_n = st.ack64_n;
  assign ctl_oe = st.ctl_oe;

endmodule // ptb_core

// >>> test/ptb_backend_model.sv
// Behavioural back-end memory controller facing the target back-end port.
// Assumes it shares core_clk and arst_n with the port.
`timescale 1ns/1ps
module ptb_backend_model #(
  parameter logic [63:0] PAT = 64'h1357_9BDF_2468_ACE0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Bench controls
  input wire logic [3:0] ready_delay,
  input wire logic withhold,
  // Port side
  input wire logic rd_flag,
  input wire logic wr_flag,
  input wire logic begin_pulse,
  input wire logic strobe,
  input wire logic [2:0] lag,
  output logic src_ready,
  output logic sink_ready,
  output logic [63:0] mem_data_in
);
  // ===========================================================
  // Pacing and data
  logic [3:0] wait_cnt;
  logic [2:0] skip;
  logic [7:0] idx;
  logic [63:0] idle_pat;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt <= 4'h0;
      skip <= 3'h0;
      idx <= 8'h00;
      idle_pat <= 64'h0F0F_0F0F_0F0F_0F0F;
    end else begin
      idle_pat <= ~idle_pat;
      if (begin_pulse) begin
        wait_cnt <= 4'h0;
        skip <= lag;
        idx <= 8'h00;
      end else begin
        // Idle cycles restart the count, so every transfer sees the full ready delay.
        if (!rd_flag && !wr_flag) wait_cnt <= 4'h0;
        else if (wait_cnt != 4'hF) wait_cnt <= wait_cnt + 4'h1;
        // Strobes during the lag count carry no data, so they do not advance the word.
        if (strobe && skip != 3'h0) skip <= skip - 3'h1;
        else if (strobe) idx <= idx + 8'h01;
      end
    end
  end
  assign src_ready = rd_flag && !withhold && wait_cnt >= ready_delay;
  assign sink_ready = wr_flag && !withhold && wait_cnt >= ready_delay;
  // Outside reads the bus is not driven, so it shows a changing pattern rather than stale data.
  assign mem_data_in = rd_flag ? PAT + {56'h0, idx} : idle_pat;
endmodule // ptb_backend_model

// >>> test/ptb_core_checker.sv
// Concurrent checks on the back-end side of ptb_core.
// Assumes one clock domain, core_clk, with arst_n as its reset.
`timescale 1ns/1ps
module ptb_core_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Watched signals
  input wire logic trdy_n,
  input wire logic [ptb_pkg::DATA_W-1:0] ad_out,
  input wire logic [ptb_pkg::DATA_W-1:0] mem_data_in,
  input wire logic backend_src_ready,
  input wire logic backend_sink_ready,
  input wire logic window_zero_hit,
  input wire logic window_one_hit,
  input wire logic cfg_space_hit,
  input wire logic rd_direction_flag,
  input wire logic wr_direction_flag,
  input wire logic xfer_begin_pulse,
  input wire logic wide_xfer_begin_pulse,
  input wire logic xfer_end_pulse,
  input wire logic rd_lane_lo_strobe,
  input wire logic rd_lane_hi_strobe,
  input wire logic [3:0] wr_lane_lo_bytes,
  input wire logic [3:0] wr_lane_hi_bytes
);
  // ===========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [4:0] flags;
  assign flags = {window_zero_hit, window_one_hit, cfg_space_hit, rd_direction_flag, wr_direction_flag};
  begin_width_a: assert property (xfer_begin_pulse |=> !xfer_begin_pulse)
    else $error("begin pulse longer than one cycle");
  end_width_a: assert property (xfer_end_pulse |=> !xfer_end_pulse)
    else $error("end pulse longer than one cycle");
  dir_exclusive_a: assert property (xfer_begin_pulse |-> rd_direction_flag ^ wr_direction_flag)
    else $error("direction flags wrong at begin");
  dir_onehot_a: assert property (!(rd_direction_flag && wr_direction_flag))
    else $error("both direction flags active");
  wide_begin_a: assert property (wide_xfer_begin_pulse |-> xfer_begin_pulse)
    else $error("wide begin without begin");
  flags_hold_a: assert property ((|flags && !xfer_end_pulse) |=> $stable(flags))
    else $error("flags changed before end pulse");
  flags_clear_a: assert property (xfer_end_pulse |=> flags == 5'h00)
    else $error("flags not cleared after end pulse");
  flag_rise_a: assert property ($rose(rd_direction_flag) || $rose(wr_direction_flag) |-> xfer_begin_pulse)
    else $error("direction flag rose without begin");
  rd_strobe_a: assert property (rd_lane_lo_strobe |-> rd_direction_flag && $past(backend_src_ready))
    else $error("read strobe without source ready");
  wr_strobe_a: assert property (|{wr_lane_hi_bytes, wr_lane_lo_bytes} |-> wr_direction_flag && $past(backend_sink_ready))
    else $error("write strobe without sink ready");
  rd_lanes_a: assert property (rd_lane_hi_strobe |-> rd_lane_lo_strobe)
    else $error("high read strobe alone");
  rd_beat_a: assert property (!trdy_n && rd_direction_flag |-> ad_out[31:0] == $past(mem_data_in[31:0]))
    else $error("read beat data not captured");
endmodule // ptb_core_checker
bind ptb_core ptb_core_checker chk_i (.core_clk(core_clk), .arst_n(arst_n), .trdy_n(trdy_n), .ad_out(ad_out),
  .mem_data_in(mem_data_in), .backend_src_ready(backend_src_ready), .backend_sink_ready(backend_sink_ready),
  .window_zero_hit(window_zero_hit), .window_one_hit(window_one_hit), .cfg_space_hit(cfg_space_hit),
  .rd_direction_flag(rd_direction_flag), .wr_direction_flag(wr_direction_flag),
  .xfer_begin_pulse(xfer_begin_pulse), .wide_xfer_begin_pulse(wide_xfer_begin_pulse),
  .xfer_end_pulse(xfer_end_pulse), .rd_lane_lo_strobe(rd_lane_lo_strobe), .rd_lane_hi_strobe(rd_lane_hi_strobe),
  .wr_lane_lo_bytes(wr_lane_lo_bytes), .wr_lane_hi_bytes(wr_lane_hi_bytes));

// >>> test/ptb_core_test.sv
// Self-checking bench for ptb_core: APB register tasks and PCI master transfers.
// Assumes the back-end model answers on core_clk.
`timescale 1ns/1ps
module ptb_core_test;
  localparam logic [63:0] PAT = 64'h1357_9BDF_2468_ACE0;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  ptb_pkg::ptb_apb_req_s apb_req = '0;
  ptb_pkg::ptb_apb_rsp_s apb_rsp;
  logic frame_n = 1'b1, irdy_n = 1'b1, req64_n = 1'b1, idsel = 1'b0, withhold = 1'b0;
  logic [7:0] cbe_n = 8'hFF;
  logic [63:0] ad_in = 64'h0, ad_out, mem_data_in, mem_data_out, wr_got, rd_got;
  logic [2:0] lag = 3'h0;
  logic [3:0] ready_delay = 4'h0, wr_lo, wr_hi;
  logic [23:0] mem_addr, addr_seen, addr_end;
  logic ad_oe, trdy_n, stop_n, devsel_n, ack64_n, ctl_oe, win0, win1, cfg, rd, wr, bgn, wbgn, fin;
  logic rd_lo, rd_hi, src_rdy, snk_rdy, mem_data_oe, wide_seen;
  logic [4:0] flags_seen;
  logic [3:0] claim_seen;
  logic [31:0] q;
  logic e;
  int failures = 0, check_count = 0, n_begin, n_end, n_strobe, n_beat, n_hi;
  always #2 core_clk = ~core_clk;
  ptb_core dut (.core_clk(core_clk), .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .frame_n(frame_n),
    .irdy_n(irdy_n), .req64_n(req64_n), .idsel(idsel), .cbe_n(cbe_n), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .trdy_n(trdy_n), .stop_n(stop_n), .devsel_n(devsel_n), .ack64_n(ack64_n), .ctl_oe(ctl_oe),
    .window_zero_hit(win0), .window_one_hit(win1), .cfg_space_hit(cfg), .rd_direction_flag(rd),
    .wr_direction_flag(wr), .mem_addr(mem_addr), .xfer_begin_pulse(bgn), .wide_xfer_begin_pulse(wbgn),
    .xfer_end_pulse(fin), .rd_lane_lo_strobe(rd_lo), .rd_lane_hi_strobe(rd_hi), .wr_lane_lo_bytes(wr_lo),
    .wr_lane_hi_bytes(wr_hi), .backend_src_ready(src_rdy), .backend_sink_ready(snk_rdy),
    .pipeline_lag_count(lag), .mem_data_in(mem_data_in), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
  ptb_backend_model #(.PAT(PAT)) be_i (.core_clk(core_clk), .arst_n(arst_n), .ready_delay(ready_delay),
    .withhold(withhold), .rd_flag(rd), .wr_flag(wr), .begin_pulse(bgn), .strobe(rd_lo || wr_lo != 4'h0 || wr_hi != 4'h0),
    .lag(lag), .src_ready(src_rdy), .sink_ready(snk_rdy), .mem_data_in(mem_data_in));
  // ===========================================================
  // Monitor of the back-end side
  always @(posedge core_clk) begin
    if (bgn === 1'b1) begin
      n_begin <= n_begin + 1;
      flags_seen <= {win0, win1, cfg, rd, wr};
      wide_seen <= wbgn;
      claim_seen <= {devsel_n, ack64_n, ctl_oe, mem_data_oe};
      addr_seen <= mem_addr;
    end
    if (rd_lo === 1'b1 || wr_lo != 4'h0 || wr_hi != 4'h0) n_strobe <= n_strobe + 1;
    if (wr_lo != 4'h0 || wr_hi != 4'h0) {wr_got, q[7:0]} <= {mem_data_out, wr_hi, wr_lo};
    if (rd_hi === 1'b1) n_hi <= n_hi + 1;
    if (trdy_n === 1'b0) {n_beat, rd_got} <= {n_beat + 1, ad_out};
    if (fin === 1'b1) {n_end, addr_end} <= {n_end + 1, mem_addr};
  end
  // ===========================================================
  // Tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic fail(input string msg);
    failures++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    check_count++;
    if (got !== exp) fail(msg);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (i == 50) begin
      fail("apb timeout");
      report_and_stop();
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic xact(input logic [3:0] cmd, input logic [31:0] a, input logic [7:0] be_n, input logic wide,
                      input logic hit);
    int i;
    {n_begin, n_end, n_strobe, n_beat, n_hi} = '0;
    @(posedge core_clk);
    {frame_n, req64_n, idsel, cbe_n, ad_in} <= {1'b0, ~wide, cmd == ptb_pkg::CMD_CFG_RD, 4'h0, cmd, 32'h0, a};
    @(posedge core_clk);
    {frame_n, req64_n, idsel, irdy_n, cbe_n, ad_in} <= {4'b1100, be_n, PAT};
    for (i = 0; i < 300; i++) begin
      @(posedge core_clk);
      if (trdy_n === 1'b0 || stop_n === 1'b0 || (!hit && i == 12)) break;
    end
    irdy_n <= 1'b1;
    for (i = 0; hit && i < 20 && n_end == 0; i++) @(posedge core_clk);
    if (hit && n_end == 0) begin
      fail("transfer timeout");
      report_and_stop();
    end
    repeat (6) @(posedge core_clk);
  endtask
  // ===========================================================
  // Sequence
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(0, ptb_pkg::OFS_CTRL, 0);
    chk(q, ptb_pkg::CTRL_RST, "ctrl reset");
    apb(0, ptb_pkg::OFS_BASE1, 0);
    chk(q, ptb_pkg::BASE1_RST, "base1 reset");
    apb(0, 8'h10, 0);
    chk({e, q}, 33'h1_0000_0000, "unmapped read");
    apb(1, ptb_pkg::OFS_BASE0, 32'h0100_0000);
    apb(1, ptb_pkg::OFS_BASE1, 32'h0000_2000);
    apb(0, ptb_pkg::OFS_BASE0, 0);
    chk(q, 32'h0100_0000, "base0 readback");
    xact(ptb_pkg::CMD_MEM_WR, 32'h0100_0040, 8'hF5, 0, 1);
    chk(flags_seen, 5'b10001, "mem write flags");
    chk(addr_seen, 24'h000040, "begin address");
    chk(q[7:0], 8'h0A, "write byte enables");
    chk(wr_got[31:0], PAT[31:0], "write data");
    chk({n_begin, n_end}, {32'd1, 32'd1}, "begin and end count");
    chk(claim_seen, 4'b0111, "write claim outputs");
    chk(addr_end, 24'h000044, "write end address");
    ready_delay <= 4'h5;
    xact(ptb_pkg::CMD_MEM_RD, 32'h0100_0080, 8'h00, 1, 1);
    chk({flags_seen, wide_seen}, 6'b100101, "wide read flags");
    chk(n_hi, 1, "high read strobe");
    chk(rd_got, PAT, "wide read data");
    chk(claim_seen, 4'b0010, "wide read claim outputs");
    chk(addr_end, 24'h000088, "wide read end address");
    lag <= 3'h2;
    xact(ptb_pkg::CMD_IO_WR, 32'h0000_2004, 8'hF0, 0, 1);
    chk(flags_seen, 5'b01001, "io write flags");
    chk({n_strobe, n_beat}, {32'd3, 32'd1}, "lag strobes");
    chk(addr_end, 24'h002010, "lag address advance");
    lag <= 3'h0;
    xact(ptb_pkg::CMD_CFG_RD, 32'h0000_0010, 8'hF0, 0, 1);
    chk(flags_seen, 5'b00110, "config flags");
    chk(rd_got[31:0], PAT[31:0], "config read data");
    withhold <= 1'b1;
    xact(ptb_pkg::CMD_MEM_RD, 32'h0100_0100, 8'hF0, 0, 1);
    chk(n_strobe, 0, "disconnect strobes");
    chk({n_beat, n_end}, {32'd0, 32'd1}, "disconnect");
    apb(0, ptb_pkg::OFS_STAT, 0);
    chk(q[17:2], 16'h0001, "disconnect count");
    withhold <= 1'b0;
    xact(ptb_pkg::CMD_MEM_RD, 32'h0500_0000, 8'hF0, 0, 0);
    chk(n_begin, 0, "miss claimed");
    report_and_stop();
  end
endmodule // ptb_core_test
